// ---- logic/hbdw_cfg.svh ----
`ifndef HBDW_CFG_SVH
`define HBDW_CFG_SVH

// host window: processor address bits 19..16 equal to this page
`define HBDW_WIN_MSB        19
`define HBDW_WIN_LSB        16
`define HBDW_WIN_PAGE       4'h4

// upper-address extension register field layout
`define HBDW_UA_ADDR_MSB    5
`define HBDW_UA_ADDR_LSB    0
`define HBDW_UA_IOPAGE_BIT  6
`define HBDW_UA_IRQ_BIT     7
`define HBDW_UA_RESET       8'h00

// reset value of the data-path latches and top bit of the low address latch
`define HBDW_WORD_RESET     16'h0000
`define HBDW_LOW_ADDR_MSB   15

`endif

// ---- logic/hbdw_irq.sv ----
`timescale 1ns/1ps
`default_nettype none

module hbdw_irq (
  input  wire logic CLK,
  input  wire logic RSTN,
  hbdw_irq_if.irq   link
);
  import hbdw_pkg::*;

  hbdw_irq_t st;       // registered state
  hbdw_irq_t next_st;  // next state
  logic      rise;     // low-to-high edge of the request bit
  logic      vstart;   // vector phase begins

  // only an edge asks; a level left high asks once
  always_comb begin
    next_st = st;
    rise   = link.req_level & ~st.prev_req;                           // see RQ13 see RQ16
    vstart = st.pending & link.ack_in & link.din & ~st.vec_phase;     // see RQ14
    next_st.prev_req = link.req_level;
    // a new edge in the acknowledge cycle is kept: set wins
    if (vstart) begin
      next_st.pending = 1'b0;
    end
    if (rise) begin
      next_st.pending = 1'b1;                                         // see RQ13
    end
    // vector stays on the lines until the host drops its strobe
    if (vstart) begin
      next_st.vec_phase = 1'b1;
    end else if (!link.din) begin
      next_st.vec_phase = 1'b0;
    end
  end

  // state register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.pending   = st.pending;
  assign link.vec_start = vstart;
  assign link.vec_phase = st.vec_phase;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  irq_edge_a: assert property (link.req_level && !st.prev_req |=> st.pending) // see RQ13
    else $error("request edge did not raise interrupt");
  irq_level_a: assert property (!st.pending && link.req_level && st.prev_req && !link.ack_in // see RQ16
    |=> !st.pending)
    else $error("held request level raised a new interrupt");
  vec_enter_a: assert property (vstart |=> st.vec_phase && !st.pending // see RQ14
    || $past(rise))
    else $error("vector phase not entered on acknowledge");
endmodule

`default_nettype wire

// ---- logic/hbdw_irq_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// carries the request level in and the interrupt phases out
interface hbdw_irq_if;
  logic req_level;  // stored host interrupt request bit
  logic ack_in;     // acknowledge daisy-chain input from host
  logic din;        // host data-in strobe
  logic pending;    // interrupt request on the backplane
  logic vec_start;  // one-cycle strobe clocking the vector
  logic vec_phase;  // vector on the data lines

  modport core (output req_level, ack_in, din, input pending, vec_start, vec_phase);
  modport irq  (input req_level, ack_in, din, output pending, vec_start, vec_phase);
endinterface

`default_nettype wire

// ---- logic/hbdw_pkg.sv ----
package hbdw_pkg;

  typedef logic [15:0] hbdw_word_t;   // backplane / processor data word
  typedef logic [19:0] hbdw_paddr_t;  // processor address
  typedef logic [7:0]  hbdw_ua_t;     // upper-address extension image

  // bus-mastership sequencing, one-hot
  typedef enum logic [2:0] {
    HBDW_IDLE   = 3'b001,
    HBDW_REQ    = 3'b010,
    HBDW_MASTER = 3'b100
  } hbdw_seq_t;

  // complete state of the bridge core
  typedef struct packed {
    hbdw_seq_t  seq;       // mastership phase
    hbdw_ua_t   upper;     // upper-address extension register
    hbdw_word_t addr_lo;   // dma low address latch
    hbdw_word_t data;      // dma transfer data register
    hbdw_word_t vector;    // vector register image
    logic       write_dir; // 1: dma write to host memory
    hbdw_word_t bdal_out;  // registered backplane data drive
  } hbdw_core_t;

  // complete state of the interrupt control
  typedef struct packed {
    logic prev_req;  // last sampled request level
    logic pending;   // request held toward the host
    logic vec_phase; // vector being presented
  } hbdw_irq_t;

endpackage

// ---- logic/hbdw_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hbdw_cfg.svh"

// Functional notes
// RQ1 - upper register loads data bits 0-5
// RQ2 - upper bits driven only with address enable
// RQ3 - firmware splits transfers at 64K boundaries
// RQ4 - upper register frozen during bus transfer
// RQ5 - data bit 6 drives I/O page line
// RQ6 - data bit 7 is host interrupt request
// RQ7 - low address latched on window access
// RQ8 - address enable: ack, no data, no in
// RQ9 - processor write in window loads data
// RQ10 - dma write drives data onto bus
// RQ11 - dma read captures bus data
// RQ12 - processor window read drives data back
// RQ13 - request rising edge raises backplane interrupt
// RQ14 - acknowledge plus data-in clocks vector out
// RQ15 - transmit asserted during vector phase
// RQ16 - new interrupt needs clear then set
// RQ17 - window address range starts dma access
// RQ18 - ack on grant, dropped after last cycle
// RQ19 - upper register resets to zero
module hbdw_top (
  input  wire logic               CLK,
  input  wire logic               RSTN,
  // processor side
  input  wire hbdw_pkg::hbdw_paddr_t PROC_ADDR,
  input  wire logic               PROC_ALE,
  input  wire logic               PROC_WR,
  input  wire logic               PROC_RD,
  input  wire logic               UPPER_ADDR_REG_SELECT,
  input  wire hbdw_pkg::hbdw_word_t PROC_DATA_IN,
  output logic [15:0]             PROC_DATA_OUT,
  output logic                    PROC_DATA_OE_N,
  output logic                    HOST_WINDOW_SELECT,
  output logic                    HOST_IRQ_REQUEST,
  // bus sequencer side
  input  wire logic               BUS_GRANT,
  input  wire logic               DATA_PHASE_ENABLE,
  input  wire logic               DATA_IN_STROBE_DRIVE,
  input  wire logic               SEQ_LAST_DONE,
  output logic                    BUS_REQUEST,
  output logic                    BUS_ACK_DRIVE,
  output logic                    ADDRESS_DRIVE_ENABLE,
  output logic                    REGISTER_OUTPUT_ENABLE,
  output logic                    REGISTER_DIRECTION,
  // backplane side
  input  wire hbdw_pkg::hbdw_word_t BDAL_IN,
  output logic [15:0]             BDAL_OUT,
  output logic                    BDAL_OE_N,
  output logic [5:0]              BDAL_HI_OUT,
  output logic                    BDAL_HI_OE_N,
  output logic                    BBS7_OUT,
  output logic                    BBS7_OE_N,
  output logic                    BIRQ_OUT,
  output logic                    BIRQ_OE_N,
  input  wire logic               BIAKI,
  input  wire logic               BDIN,
  output logic                    TRANSCEIVER_TRANSMIT,
  input  wire hbdw_pkg::hbdw_word_t VECTOR_IN
);
  import hbdw_pkg::*;

  hbdw_core_t st;          // registered state of the bridge
  hbdw_core_t next_st;     // next state
  logic       win_hit;     // processor address inside host window
  logic       win_wr;      // processor write into host window
  logic       win_rd;      // processor read from host window
  logic       ua_wr;       // accepted upper-register write
  logic       addr_drive;  // address phase toward backplane
  logic       data_drive;  // write data phase toward backplane
  logic       bus_load;    // read data phase from backplane
  logic       idle;        // no transfer in progress

  hbdw_irq_if irq_link (); // carrier to the interrupt control

  // the window is one 64K page of processor space; reused by every
  // strobe decode so the range lives in one place
  function automatic logic in_window(input hbdw_paddr_t a);
    in_window = (a[`HBDW_WIN_MSB:`HBDW_WIN_LSB] == `HBDW_WIN_PAGE);
  endfunction

  // processor-side strobe decodes
  always_comb begin
    win_hit = in_window(PROC_ADDR);                     // see RQ17
    win_wr  = PROC_WR & in_window(PROC_ADDR);           // see RQ9
    win_rd  = PROC_RD & in_window(PROC_ADDR);           // see RQ12
  end

  // backplane phase decodes from the sequencer strobes
  always_comb begin
    idle       = (st.seq == HBDW_IDLE);
    // address only while acknowledged and neither data strobe is up
    addr_drive = BUS_ACK_DRIVE & ~DATA_PHASE_ENABLE
                 & ~DATA_IN_STROBE_DRIVE;               // see RQ8
    // write data goes out in the data phase of a write transfer
    data_drive = BUS_ACK_DRIVE & DATA_PHASE_ENABLE
                 & st.write_dir;                        // see RQ10
    // read data is caught in the data phase of a read transfer
    bus_load   = BUS_ACK_DRIVE & DATA_PHASE_ENABLE
                 & ~st.write_dir;                       // see RQ11
    // the upper page cannot move under a live transfer, so the
    // write is dropped outside idle; software must split its work
    // so that each 64K crossing falls between transfers
    ua_wr      = PROC_WR & UPPER_ADDR_REG_SELECT & idle; // see RQ1 see RQ4 see RQ3
  end

  // next state of the whole bridge
  always_comb begin
    next_st = st;

    // mastership sequencing
    case (st.seq)
      HBDW_IDLE: begin
        // any window address strobe asks for the backplane
        if (PROC_ALE && win_hit) begin
          next_st.seq = HBDW_REQ;                       // see RQ17
        end
      end
      HBDW_REQ: begin
        // grant seen: take the bus
        if (BUS_GRANT) begin
          next_st.seq = HBDW_MASTER;                    // see RQ18
        end
      end
      HBDW_MASTER: begin
        // last cycle finished or aborted: give it back
        if (SEQ_LAST_DONE) begin
          next_st.seq = HBDW_IDLE;                      // see RQ18
        end
      end
      default: begin
        // illegal code recovers to idle
        next_st.seq = HBDW_IDLE;
      end
    endcase

    // upper-address extension: address page, i/o page, request bit
    if (ua_wr) begin
      next_st.upper = PROC_DATA_IN[7:0];                // see RQ1 see RQ5 see RQ6
    end

    // low address is taken at every window address strobe
    if (PROC_ALE && win_hit) begin
      next_st.addr_lo = PROC_ADDR[`HBDW_LOW_ADDR_MSB:0]; // see RQ7
    end

    // transfer direction follows the last processor strobe in idle
    if (idle && win_wr) begin
      next_st.write_dir = 1'b1;
    end else if (idle && win_rd) begin
      next_st.write_dir = 1'b0;
    end

    // data register: processor load for writes, bus load for reads
    if (win_wr) begin
      next_st.data = PROC_DATA_IN;                      // see RQ9
    end else if (bus_load) begin
      next_st.data = BDAL_IN;                           // see RQ11
    end

    // vector register is clocked at the start of the vector phase
    if (irq_link.vec_start) begin
      next_st.vector = VECTOR_IN;                       // see RQ14
    end

    // registered backplane data; a phase change shows one cycle
    // later on the lines, traded for glitch-free data pins
    if (addr_drive) begin
      next_st.bdal_out = st.addr_lo;
    end else if (irq_link.vec_phase) begin
      next_st.bdal_out = st.vector;                     // see RQ15
    end else if (data_drive) begin
      next_st.bdal_out = st.data;                       // see RQ10
    end else begin
      next_st.bdal_out = `HBDW_WORD_RESET;
    end
  end

  // state register; reset clears the upper page and request bit
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st.seq       <= HBDW_IDLE;
      st.upper     <= `HBDW_UA_RESET;                   // see RQ19
      st.addr_lo   <= `HBDW_WORD_RESET;
      st.data      <= `HBDW_WORD_RESET;
      st.vector    <= `HBDW_WORD_RESET;
      st.write_dir <= 1'b0;
      st.bdal_out  <= `HBDW_WORD_RESET;
    end else begin
      st <= next_st;
    end
  end

  // interrupt control gets the stored request bit
  assign irq_link.req_level = st.upper[`HBDW_UA_IRQ_BIT]; // see RQ6
  assign irq_link.ack_in    = BIAKI;
  assign irq_link.din       = BDIN;

  hbdw_irq hbdw_irq_inst (
    .CLK  (CLK),
    .RSTN (RSTN),
    .link (irq_link)
  );

  // sequencer handshake
  assign BUS_REQUEST          = (st.seq == HBDW_REQ);
  assign BUS_ACK_DRIVE        = (st.seq == HBDW_MASTER);  // see RQ18
  assign ADDRESS_DRIVE_ENABLE = addr_drive;

  // data register enable and direction: 1 toward backplane
  assign REGISTER_OUTPUT_ENABLE = data_drive | win_rd;    // see RQ10 see RQ12
  assign REGISTER_DIRECTION     = data_drive;             // see RQ12

  // processor read-back of the data register
  assign PROC_DATA_OUT  = st.data;
  assign PROC_DATA_OE_N = ~win_rd;                        // see RQ12

  assign HOST_WINDOW_SELECT = win_hit;
  assign HOST_IRQ_REQUEST   = st.upper[`HBDW_UA_IRQ_BIT];

  // upper address and i/o page go out only in the address phase
  assign BDAL_HI_OUT  = st.upper[`HBDW_UA_ADDR_MSB:`HBDW_UA_ADDR_LSB]; // see RQ2
  assign BDAL_HI_OE_N = ~addr_drive;                      // see RQ2
  assign BBS7_OUT     = st.upper[`HBDW_UA_IOPAGE_BIT];    // see RQ5
  assign BBS7_OE_N    = ~addr_drive;                      // see RQ5

  // backplane data lines
  assign BDAL_OUT  = st.bdal_out;
  assign BDAL_OE_N = ~(addr_drive | data_drive | irq_link.vec_phase);
  assign TRANSCEIVER_TRANSMIT = addr_drive | data_drive
                                | irq_link.vec_phase;     // see RQ15

  // interrupt request line, active while an interrupt is pending
  assign BIRQ_OUT  = irq_link.pending;                    // see RQ13
  assign BIRQ_OE_N = ~irq_link.pending;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // a window access followed by grant
  sequence s_acquire;
    (st.seq == HBDW_REQ) && BUS_GRANT;
  endsequence

  sequence s_release;
    BUS_ACK_DRIVE && SEQ_LAST_DONE;
  endsequence

  sequence s_window_start;
    idle && PROC_ALE && win_hit;
  endsequence

  ua_load_a: assert property (PROC_WR && UPPER_ADDR_REG_SELECT && idle // see RQ1
    |=> st.upper == $past(PROC_DATA_IN[7:0]))
    else $error("upper register not loaded");
  ua_frozen_a: assert property (!idle |=> $stable(st.upper)) // see RQ4
    else $error("upper register changed during transfer");
  ua_drive_a: assert property (!BDAL_HI_OE_N |-> BUS_ACK_DRIVE // see RQ2
    && !DATA_PHASE_ENABLE && !DATA_IN_STROBE_DRIVE && !BBS7_OE_N)
    else $error("upper address driven outside address phase");
  bus_grant_a: assert property (s_acquire |=> BUS_ACK_DRIVE ##0 !BUS_REQUEST) // see RQ18
    else $error("acknowledge not raised on grant");
  bus_release_a: assert property (s_release |=> !BUS_ACK_DRIVE [*2]) // see RQ18
    else $error("acknowledge not dropped after last cycle");
  win_start_a: assert property (s_window_start |=> BUS_REQUEST // see RQ17
    ##0 st.addr_lo == $past(PROC_ADDR[15:0]))
    else $error("window access did not start request");
  dma_wr_load_a: assert property (win_wr |=> st.data == $past(PROC_DATA_IN)) // see RQ9
    else $error("data register not loaded by processor");
  dma_rd_load_a: assert property (bus_load && !win_wr // see RQ11
    |=> st.data == $past(BDAL_IN))
    else $error("data register not loaded from backplane");
  dma_wr_out_a: assert property (data_drive && !addr_drive && !irq_link.vec_phase // see RQ10
    |=> BDAL_OUT == $past(st.data))
    else $error("write data not presented to backplane");
  proc_read_a: assert property (win_rd |-> !PROC_DATA_OE_N // see RQ12
    && REGISTER_OUTPUT_ENABLE && (PROC_DATA_OUT == st.data))
    else $error("window read not returned to processor");
  vec_out_a: assert property (irq_link.vec_start |=> TRANSCEIVER_TRANSMIT // see RQ15
    && !BDAL_OE_N)
    else $error("vector not transmitted");

  // write data phase of a dma write
  sequence s_write_phase;
    BUS_ACK_DRIVE && DATA_PHASE_ENABLE && st.write_dir;
  endsequence

  // address enable follows the sequencer decode at all times
  addr_enable_a: assert property (ADDRESS_DRIVE_ENABLE == (BUS_ACK_DRIVE // see RQ8
    && !DATA_PHASE_ENABLE && !DATA_IN_STROBE_DRIVE))
    else $error("address enable decode wrong");

  // request waits for grant
  req_hold_a: assert property (BUS_REQUEST && !BUS_GRANT // see RQ18
    |=> BUS_REQUEST)
    else $error("request dropped before grant");

  // mastership kept until the last cycle ends
  ack_hold_a: assert property (BUS_ACK_DRIVE && !SEQ_LAST_DONE // see RQ18
    |=> BUS_ACK_DRIVE)
    else $error("acknowledge dropped early");

  // every window address strobe relatches, inside a transfer too
  lo_latch_a: assert property (PROC_ALE && win_hit // see RQ7
    |=> st.addr_lo == $past(PROC_ADDR[15:0]))
    else $error("low address not latched");

  // a processor window read turns the register toward the processor
  rd_dir_a: assert property (win_rd && !data_drive // see RQ12
    |-> REGISTER_OUTPUT_ENABLE && !REGISTER_DIRECTION)
    else $error("read direction wrong");

  // write data reaches the transceivers
  wr_dir_a: assert property (s_write_phase // see RQ10
    |-> REGISTER_OUTPUT_ENABLE && REGISTER_DIRECTION && TRANSCEIVER_TRANSMIT && !BDAL_OE_N)
    else $error("write data not enabled");

  // in a read data phase the host owns the lines
  rd_float_a: assert property (BUS_ACK_DRIVE && DATA_PHASE_ENABLE && !st.write_dir // see RQ11
    && !irq_link.vec_phase |-> BDAL_OE_N && !REGISTER_DIRECTION)
    else $error("read phase drove backplane");

  // the upper register moves only on an accepted write
  ua_quiet_a: assert property (!ua_wr |=> $stable(st.upper)) // see RQ1
    else $error("upper register changed without write");

  // a new request edge reaches the backplane next cycle
  irq_rise_a: assert property ($rose(HOST_IRQ_REQUEST) // see RQ13
    |=> BIRQ_OUT && !BIRQ_OE_N)
    else $error("request edge not on backplane");

  // vector phase hands the latched vector to the data lines
  vec_data_a: assert property (irq_link.vec_phase && !addr_drive // see RQ15
    |=> BDAL_OUT == $past(st.vector))
    else $error("vector not on data lines");

  // vector is caught when the phase starts
  vec_latch_a: assert property (irq_link.vec_start // see RQ14
    |=> st.vector == $past(VECTOR_IN))
    else $error("vector not latched");

  // transmit held for the whole vector phase
  vec_xmit_a: assert property (irq_link.vec_phase // see RQ15
    |-> TRANSCEIVER_TRANSMIT && !BDAL_OE_N)
    else $error("transmit dropped in vector phase");
endmodule

`default_nettype wire

// ---- verif/hbdw_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// host cpu and memory seen from the backplane
module hbdw_host_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        slow,        // long arbitration before grant
  input  wire logic        bus_request,
  input  wire logic        bus_ack,
  input  wire logic        data_phase,
  input  wire logic        birq,
  input  wire logic        birq_oe_n,
  input  wire logic        transmit,
  input  wire logic [15:0] bdal_out,
  input  wire logic [15:0] rd_word,     // memory word for reads
  output logic             grant,
  output logic             biaki,
  output logic             bdin,
  output logic [15:0]      bdal_in,
  output logic [15:0]      vector_seen  // last word read in vector phase
);
  logic [3:0] wait_cnt;  // arbitration delay
  logic [2:0] iack_cnt;  // length of the acknowledge cycle

  // memory drives only in the data phase; floating lines show garbage
  assign bdal_in = (bus_ack && data_phase) ? rd_word : ~rd_word;

  // grant follows the request and ends once mastership is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      grant    <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (bus_ack) begin
      grant    <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (bus_request) begin
      wait_cnt <= wait_cnt + 4'h1;
      grant    <= grant || !slow || (wait_cnt == 4'h4);
    end
  end

  // interrupt acknowledge: daisy chain and data-in held five cycles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      biaki       <= 1'b0;
      bdin        <= 1'b0;
      iack_cnt    <= 3'h0;
      vector_seen <= 16'h0000;
    end else begin
      if (bdin && transmit) begin
        vector_seen <= bdal_out;
      end
      if (iack_cnt != 3'h0) begin
        iack_cnt <= iack_cnt + 3'h1;
        if (iack_cnt == 3'h5) begin
          biaki    <= 1'b0;
          bdin     <= 1'b0;
          iack_cnt <= 3'h0;
        end
      end else if (birq && !birq_oe_n) begin
        biaki    <= 1'b1;
        bdin     <= 1'b1;
        iack_cnt <= 3'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- verif/test_host_bus_dma_window_and_irq.sv ----
`timescale 1ns/1ps
`default_nettype none

// self-checking bench for the host bus bridge
module test_host_bus_dma_window_and_irq;
  import hbdw_pkg::*;
  localparam hbdw_word_t VEC   = 16'h01a4;  // vector handed to the host
  localparam hbdw_word_t VEC2  = 16'h01b0;  // vector of the second interrupt
  localparam int         LIMIT = 3000;      // hang ceiling in cycles

  logic        clk, rstn, ale, wr, rd, sel, dph, dins, last, slow;
  logic        grant, biaki, bdin, win, irq, breq, ack, ade, roe, rdir;
  logic        pdoe_n, bdoe_n, hioe_n, bbs7, bbs7oe_n, birq, birqoe_n, xmit;
  logic [5:0]  hi;     // upper address lines
  hbdw_paddr_t addr;   // processor address
  hbdw_word_t  wdata, rdw, bdal_in, bdal_out, pdout, vseen, vec_in;
  int          bad_count, samples_checked, cycles;

  hbdw_top hbdw_top_inst (.CLK(clk), .RSTN(rstn), .PROC_ADDR(addr), .PROC_ALE(ale),
    .PROC_WR(wr), .PROC_RD(rd), .UPPER_ADDR_REG_SELECT(sel), .PROC_DATA_IN(wdata),
    .PROC_DATA_OUT(pdout), .PROC_DATA_OE_N(pdoe_n), .HOST_WINDOW_SELECT(win),
    .HOST_IRQ_REQUEST(irq), .BUS_GRANT(grant), .DATA_PHASE_ENABLE(dph),
    .DATA_IN_STROBE_DRIVE(dins), .SEQ_LAST_DONE(last), .BUS_REQUEST(breq),
    .BUS_ACK_DRIVE(ack), .ADDRESS_DRIVE_ENABLE(ade), .REGISTER_OUTPUT_ENABLE(roe),
    .REGISTER_DIRECTION(rdir), .BDAL_IN(bdal_in), .BDAL_OUT(bdal_out),
    .BDAL_OE_N(bdoe_n), .BDAL_HI_OUT(hi), .BDAL_HI_OE_N(hioe_n), .BBS7_OUT(bbs7),
    .BBS7_OE_N(bbs7oe_n), .BIRQ_OUT(birq), .BIRQ_OE_N(birqoe_n), .BIAKI(biaki),
    .BDIN(bdin), .TRANSCEIVER_TRANSMIT(xmit), .VECTOR_IN(vec_in));

  hbdw_host_model hbdw_host_model_inst (.clk(clk), .rstn(rstn), .slow(slow),
    .bus_request(breq), .bus_ack(ack), .data_phase(dph), .birq(birq),
    .birq_oe_n(birqoe_n), .transmit(xmit), .bdal_out(bdal_out), .rd_word(rdw),
    .grant(grant), .biaki(biaki), .bdin(bdin), .bdal_in(bdal_in), .vector_seen(vseen));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run, reached from the main flow or the hang guard
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one comparison, counted
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step;
    @(negedge clk);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return ack;
      1: return birq;
      default: return bdin;
    endcase
  endfunction

  // bounded wait for a handshake level, then judged
  task automatic wait_for(input int w, input logic lvl);
    int n;
    n = 0;
    while (pick(w) !== lvl && n < 40) begin
      step;
      n++;
    end
    check(16'(pick(w)), 16'(lvl));
  endtask

  // upper register write; a spare cycle keeps strobes apart
  task automatic upper_write(input logic [7:0] v);
    addr  = 20'h00000;
    wdata = {8'hff, v};
    wr    = 1'b1;
    sel   = 1'b1;
    step;
    wr  = 1'b0;
    sel = 1'b0;
    step;
  endtask

  task automatic t_reset;
    check(16'({irq, bbs7, hi}), 16'h0000);
    check(16'({birq, ack, breq}), 16'h0000);
    check(16'({hioe_n, bbs7oe_n, birqoe_n}), 16'h0007);
    $display("test reset done");
  endtask

  task automatic t_upper;
    upper_write(8'h6a);
    check(16'(hi), 16'h002a);
    check(16'({irq, bbs7}), 16'h0001);
    check(16'(hioe_n), 16'h0001);
    $display("test upper done");
  endtask

  // dma write with a slow grant and a refused upper write inside
  task automatic t_dma_write;
    slow  = 1'b1;
    addr  = 20'h41234;
    wdata = 16'hbeef;
    wr    = 1'b1;
    step;
    check(16'(win), 16'h0001);
    wr  = 1'b0;
    ale = 1'b1;
    step;
    ale  = 1'b0;
    addr = 20'h00000;
    wait_for(0, 1'b1);
    check(16'({ade, hioe_n, bbs7oe_n, xmit}), 16'h0009);
    upper_write(8'h3f);
    check(bdal_out, 16'h1234);
    check(16'(hi), 16'h002a);
    dph = 1'b1;
    step;
    check(16'({ade, roe, rdir, bdoe_n}), 16'h0006);
    check(bdal_out, 16'hbeef);
    dph  = 1'b0;
    last = 1'b1;
    step;
    last = 1'b0;
    check(16'({ack, hioe_n}), 16'h0001);
    $display("test dma write done");
  endtask

  // window miss on the next 64K page, then a dma read at the top of the window
  task automatic t_dma_read;
    slow = 1'b0;
    addr = 20'h50000;
    ale  = 1'b1;
    step;
    ale = 1'b0;
    step;
    check(16'({win, breq}), 16'h0000);
    upper_write(8'h05);
    addr = 20'h4fffe;
    rd   = 1'b1;
    step;
    rd  = 1'b0;
    ale = 1'b1;
    rdw = 16'h5a3c;
    step;
    ale = 1'b0;
    wait_for(0, 1'b1);
    check(16'({bbs7, hi}), 16'h0005);
    dins = 1'b1;
    step;
    check(16'(ade), 16'h0000);
    dins = 1'b0;
    dph  = 1'b1;
    step;
    check(16'({roe, bdoe_n}), 16'h0001);
    dph  = 1'b0;
    last = 1'b1;
    step;
    last = 1'b0;
    rd   = 1'b1;
    #1;
    check(16'({pdoe_n, roe, rdir}), 16'h0002);
    check(pdout, 16'h5a3c);
    step;
    rd = 1'b0;
    $display("test dma read done");
  endtask

  // interrupt, vector phase, held bit, then clear and set again
  task automatic t_irq;
    upper_write(8'h80);
    check(16'(irq), 16'h0001);
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    step;
    check(16'({xmit, bdoe_n, birq}), 16'h0004);
    vec_in = 16'hffff;
    wait_for(2, 1'b0);
    check(vseen, VEC);
    vec_in = VEC2;
    upper_write(8'h80);
    repeat (5) step;
    check(16'({birq, bdin}), 16'h0000);
    upper_write(8'h00);
    upper_write(8'h80);
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    wait_for(2, 1'b0);
    check(vseen, VEC2);
    $display("test irq done");
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      final_report;
    end
  end

  // main sequence; inputs change on the falling edge
  initial begin
    {rstn, ale, wr, rd, sel, dph, dins, last, slow} = '0;
    addr  = 20'h00000;
    wdata = 16'h0000;
    rdw   = 16'h0000;
    vec_in = VEC;
    {bad_count, samples_checked, cycles} = '0;
    repeat (3) @(posedge clk);
    step;
    rstn = 1'b1;
    step;
    t_reset;
    t_upper;
    t_dma_write;
    t_dma_read;
    t_irq;
    final_report;
  end
endmodule

`default_nettype wire
